// File: core/mdu_pkg.sv
package mdu_pkg;

    // ------------------------------------------------------------
    // Register map and field layout
    // ------------------------------------------------------------
    localparam logic addr_data = 1'b0;
    localparam logic addr_stat = 1'b1;
    localparam int stat_busy_bit = 6;
    localparam int stat_empty_bit = 7;
    localparam logic [7:0] stat_reset = 8'h80;

    // ------------------------------------------------------------
    // Command codes and acknowledge byte
    // ------------------------------------------------------------
    localparam logic [7:0] cmd_reset = 8'hff;
    localparam logic [7:0] cmd_passthru = 8'h3f;
    localparam logic [7:0] ack_byte = 8'hfe;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int clk_mhz = 200;
    localparam int baud_rate = 31250;
    localparam int bit_cycles = clk_mhz * 1000000 / baud_rate;
    localparam int half_cycles = bit_cycles / 2;
    localparam int frame_bits = 10;
    localparam int fifo_depth = 16;

    // Serial engine states
    typedef enum logic [1:0] {
        mdu_idle_s = 2'b00,
        mdu_start_s = 2'b01,
        mdu_data_s = 2'b10,
        mdu_stop_s = 2'b11
    } mdu_ser_t;

    // Host register request
    typedef struct packed {
        logic addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } mdu_req_t;

    // FIFO request to the memory module
    typedef struct packed {
        logic we;
        logic [3:0] waddr;
        logic [7:0] wdata;
        logic [3:0] raddr;
    } mdu_mem_req_t;

endpackage

// File: core/mdu_mem.sv
`timescale 1ns/1ps
`default_nettype none
module mdu_mem #(
    parameter int aw = 4
) (
    input wire logic clk,
    input wire mdu_pkg::mdu_mem_req_t req,
    output logic [7:0] rdata
);
    logic [7:0] mem [2**aw];

    // Synchronous write, registered read
    always_ff @(posedge clk) begin
        if (req.we) begin
            mem[req.waddr] <= req.wdata;
        end
        rdata <= mem[req.raddr];
    end
endmodule
`default_nettype wire

// File: core/mdu_uart.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Status bit6 busy, bit7 empty, reset 0x80
// - Status bits 5..0 read zero
// - Empty flag zero while byte waits
// - Interrupt high exactly while empty low and activated
// - Busy flag one while transmit FIFO full
// - Interrupt only from receive availability
// - Data read drops interrupt once drained
// - Interrupt forced low when not activated
// - Only commands FFh and 3Fh act
// - Reset command leaves mode, flushes receive
// - Reset acknowledged only outside pass-through
// - Reset state discards serial and host data
// - Reset state after command and power-on
// - Pass-through command flushes, acks, enables
// - Pass-through repeated in mode ignored
// - Pass-through moves bytes unchanged
// - Acknowledge precedes data, after flush
// - Availability after one received byte
// - 31.25k baud, 8N1 frames
// - Data bits least significant first
// - Full duplex, 16-byte FIFOs each
// - Data port readable and writable
module mdu_uart #(
    parameter int depth = mdu_pkg::fifo_depth,
    parameter int bit_cnt = mdu_pkg::bit_cycles
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [0:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic activate,
    input wire logic serial_music_in,
    output logic serial_music_out,
    output logic irq
);
    localparam int aw = $clog2(depth);
    localparam logic [15:0] bit_n = 16'(bit_cnt - 1);
    localparam logic [15:0] half_n = 16'(bit_cnt / 2 - 1);
    localparam logic [3:0] last_bit = 4'(mdu_pkg::frame_bits - 3);

    initial begin
        if (depth != 16 || bit_cnt < 4 || bit_cnt > 65535) begin
            $error("mdu_uart: unsupported depth or bit count");
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic mode;
        logic ack;
        logic [aw:0] rx_cnt;
        logic [aw-1:0] rx_wp;
        logic [aw-1:0] rx_rp;
        logic [7:0] byp;
        logic byp_v;
        logic [aw:0] tx_cnt;
        logic [aw-1:0] tx_wp;
        logic [aw-1:0] tx_rp;
        mdu_pkg::mdu_ser_t ts;
        logic [15:0] tdiv;
        logic [3:0] tbit;
        logic [7:0] tsh;
        logic tpend;
        mdu_pkg::mdu_ser_t rs;
        logic [15:0] rdiv;
        logic [3:0] rbit;
        logic [7:0] rsh;
        logic [7:0] rd;
        logic rd_sel;
        logic txo;
        logic irq;
    } mdu_st_t;

    mdu_st_t s_q, s_d;
    mdu_pkg::mdu_mem_req_t rxm, txm;
    logic [7:0] rx_rdata, tx_rdata;
    logic rx_empty_flag, tx_busy, host_data_read_strobe;

    // ------------------------------------------------------------
    // FIFO storage
    // ------------------------------------------------------------
    mdu_mem #(.aw(aw)) u_rx (
        .clk(clk),
        .req(rxm),
        .rdata(rx_rdata)
    );

    mdu_mem #(.aw(aw)) u_tx (
        .clk(clk),
        .req(txm),
        .rdata(tx_rdata)
    );

    // Flags seen by host
    assign rx_empty_flag = !(s_q.ack || s_q.rx_cnt != '0);
    assign tx_busy = s_q.tx_cnt[aw];
    assign host_data_read_strobe = rd_stb && addr == mdu_pkg::addr_data;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic rx_pop, rx_push, tx_push, tx_pop;
        logic [7:0] st;
        logic [7:0] head;
        // Head of the receive FIFO; a byte just written bypasses the RAM
        head = s_q.byp_v ? s_q.byp : rx_rdata;
        st = 8'h00;
        s_d = s_q;
        rx_pop = 1'b0;
        rx_push = 1'b0;
        tx_push = 1'b0;
        tx_pop = 1'b0;
        rxm = '0;
        txm = '0;
        rxm.raddr = s_q.rx_rp;
        txm.raddr = s_q.tx_rp;

        // Receive serial engine, samples mid-bit, LSB first
        unique case (s_q.rs)
            mdu_pkg::mdu_idle_s: begin
                if (!serial_music_in) begin
                    s_d.rs = mdu_pkg::mdu_start_s;
                    s_d.rdiv = half_n;
                end
            end
            mdu_pkg::mdu_start_s: begin
                if (s_q.rdiv == '0) begin
                    s_d.rs = serial_music_in ? mdu_pkg::mdu_idle_s
                                             : mdu_pkg::mdu_data_s;
                    s_d.rdiv = bit_n;
                    s_d.rbit = '0;
                end else begin
                    s_d.rdiv = s_q.rdiv - 16'h1;
                end
            end
            mdu_pkg::mdu_data_s: begin
                if (s_q.rdiv == '0) begin
                    s_d.rsh = {serial_music_in, s_q.rsh[7:1]};
                    s_d.rdiv = bit_n;
                    s_d.rbit = s_q.rbit + 4'h1;
                    if (s_q.rbit == last_bit) begin
                        s_d.rs = mdu_pkg::mdu_stop_s;
                    end
                end else begin
                    s_d.rdiv = s_q.rdiv - 16'h1;
                end
            end
            mdu_pkg::mdu_stop_s: begin
                if (s_q.rdiv == '0) begin
                    s_d.rs = mdu_pkg::mdu_idle_s;
                    // Framing errors dropped; full FIFO drops byte
                    rx_push = serial_music_in && s_q.mode
                              && !s_q.rx_cnt[aw];
                end else begin
                    s_d.rdiv = s_q.rdiv - 16'h1;
                end
            end
        endcase

        // Host read of the data port, acknowledge first
        if (host_data_read_strobe) begin
            if (s_q.ack) begin
                s_d.ack = 1'b0;
            end else if (s_q.rx_cnt != '0) begin
                rx_pop = 1'b1;
            end
        end
        s_d.rd_sel = host_data_read_strobe && !s_q.ack;
        st = {rx_empty_flag, tx_busy, 6'h00};
        s_d.rd = host_data_read_strobe
                 ? (s_q.ack ? mdu_pkg::ack_byte
                            : (s_q.rx_cnt != '0 ? head : 8'h00))
                 : (rd_stb ? st : 8'h00);

        // Host write of the data port
        if (wr_stb && addr == mdu_pkg::addr_data && s_q.mode
            && !tx_busy) begin
            tx_push = 1'b1;
        end

        // Transmit serial engine
        s_d.tpend = 1'b0;
        unique case (s_q.ts)
            mdu_pkg::mdu_idle_s: begin
                s_d.txo = 1'b1;
                if (s_q.tpend) begin
                    s_d.tsh = tx_rdata;
                    s_d.ts = mdu_pkg::mdu_start_s;
                    s_d.tdiv = bit_n;
                    s_d.txo = 1'b0;
                end else if (s_q.tx_cnt != '0 && s_q.mode) begin
                    tx_pop = 1'b1;
                    s_d.tpend = 1'b1;
                end
            end
            mdu_pkg::mdu_start_s, mdu_pkg::mdu_data_s: begin
                if (s_q.tdiv == '0) begin
                    s_d.tdiv = bit_n;
                    s_d.txo = s_q.tsh[0];
                    s_d.tsh = {1'b1, s_q.tsh[7:1]};
                    if (s_q.ts == mdu_pkg::mdu_start_s) begin
                        s_d.tbit = '0;
                        s_d.ts = mdu_pkg::mdu_data_s;
                    end else begin
                        s_d.tbit = s_q.tbit + 4'h1;
                        if (s_q.tbit == last_bit) begin
                            s_d.ts = mdu_pkg::mdu_stop_s;
                            s_d.txo = 1'b1; // stop bit
                        end
                    end
                end else begin
                    s_d.tdiv = s_q.tdiv - 16'h1;
                end
            end
            mdu_pkg::mdu_stop_s: begin
                if (s_q.tdiv == '0) begin
                    s_d.ts = mdu_pkg::mdu_idle_s;
                end else begin
                    s_d.tdiv = s_q.tdiv - 16'h1;
                end
            end
        endcase

        // FIFO pointers and counts, full duplex
        rxm.we = rx_push;
        rxm.waddr = s_q.rx_wp;
        rxm.wdata = s_q.rsh;
        txm.we = tx_push;
        txm.waddr = s_q.tx_wp;
        txm.wdata = wdata;
        if (rx_push) begin
            s_d.rx_wp = s_q.rx_wp + 1'b1;
        end
        if (rx_pop) begin
            s_d.rx_rp = s_q.rx_rp + 1'b1;
        end
        s_d.rx_cnt = s_q.rx_cnt + (aw+1)'(rx_push) - (aw+1)'(rx_pop);
        if (tx_push) begin
            s_d.tx_wp = s_q.tx_wp + 1'b1;
        end
        if (tx_pop) begin
            s_d.tx_rp = s_q.tx_rp + 1'b1;
        end
        s_d.tx_cnt = s_q.tx_cnt + (aw+1)'(tx_push) - (aw+1)'(tx_pop);

        // Command controller, acts at once
        if (wr_stb && addr == mdu_pkg::addr_stat) begin
            if (wdata == mdu_pkg::cmd_reset) begin
                s_d.mode = 1'b0;
                s_d.rx_cnt = '0;
                s_d.rx_wp = '0;
                s_d.rx_rp = '0;
                s_d.tx_cnt = '0;
                s_d.tx_wp = '0;
                s_d.tx_rp = '0;
                s_d.tpend = 1'b0;
                s_d.ack = !s_q.mode;
            end else if (wdata == mdu_pkg::cmd_passthru && !s_q.mode) begin
                s_d.mode = 1'b1;
                s_d.rx_cnt = '0;
                s_d.rx_wp = '0;
                s_d.rx_rp = '0;
                s_d.tx_cnt = '0;
                s_d.tx_wp = '0;
                s_d.tx_rp = '0;
                s_d.tpend = 1'b0;
                s_d.ack = 1'b1;
            end
        end
        // Outside pass-through the transmit engine is held idle with the line high
        if (!s_d.mode) begin
            s_d.ts = mdu_pkg::mdu_idle_s;
            s_d.txo = 1'b1;
        end

        // RAM prefetches the next head; same-edge write goes via bypass
        rxm.raddr = s_d.rx_rp;
        s_d.byp = s_q.rsh;
        s_d.byp_v = rx_push && s_q.rx_wp == s_d.rx_rp;

        // Interrupt follows the empty flag, gated by activate
        s_d.irq = activate && (s_d.ack || s_d.rx_cnt != '0);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.txo <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Read data: FIFO word selected after a data read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= s_d.rd;
        end
    end

    assign serial_music_out = s_q.txo;
    assign irq = s_q.irq;
endmodule
`default_nettype wire

// File: tb/mdu_uart_sva.sv
`timescale 1ns/1ps
`default_nettype none
module mdu_uart_sva #(
    parameter int depth = 16,
    parameter int bit_cnt = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [0:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] rdata,
    input wire logic activate,
    input wire logic serial_music_in,
    input wire logic serial_music_out,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Length of the current low run on the serial output
    int lo_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lo_q <= 0;
        end else begin
            lo_q <= serial_music_out ? 0 : lo_q + 1;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_irq_gate: assert property (
        !activate ##1 !activate |-> !irq)
        else $error("irq high while not activated");
    a_rdata_idle: assert property (
        !rd_stb |=> rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_stat_resv: assert property (
        rd_stb && addr == 1'b1 |=> rdata[5:0] == 6'h00)
        else $error("reserved status bits not zero");
    a_empty_irq: assert property (
        activate ##1 (rd_stb && addr == 1'b1) |=> rdata[7] == !$past(irq))
        else $error("empty flag disagrees with irq");
    a_reset_vals: assert property (
        $fell(sys_rst) |-> serial_music_out && !irq && rdata == 8'h00)
        else $error("outputs wrong after reset");
    a_cmd_other: assert property (
        wr_stb && addr == 1'b1 && wdata != mdu_pkg::cmd_reset &&
        wdata != mdu_pkg::cmd_passthru && activate ##1 activate
        |-> $stable(irq))
        else $error("unknown command changed irq");
    a_data_wr: assert property (
        wr_stb && addr == 1'b0 && activate ##1 activate |-> !$rose(irq))
        else $error("data write raised irq");
    a_frame_low: assert property (
        $rose(serial_music_out)
        |-> lo_q % bit_cnt == 0 && lo_q <= 9 * bit_cnt)
        else $error("serial low run not whole bits");

    // Main scenarios
    c_irq: cover property ($rose(irq));
    c_tx: cover property ($fell(serial_music_out));
    c_rd: cover property (rd_stb && addr == 1'b0 && irq);
endmodule

bind mdu_uart mdu_uart_sva #(.depth(depth), .bit_cnt(bit_cnt)) u_sva (
    .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .activate(activate), .serial_music_in(serial_music_in),
    .serial_music_out(serial_music_out), .irq(irq));
`default_nettype wire

// File: tb/mdu_inst_model.sv
`timescale 1ns/1ps
`default_nettype none
module mdu_inst_model #(
    parameter int bit_cnt = 16
) (
    input wire logic clk,
    output logic to_dev,
    input wire logic from_dev
);
    logic [7:0] got[$];
    logic [7:0] sh;

    // Line idles high between frames
    initial to_dev = 1'b1;

    // Send one 8N1 frame, least significant bit first
    task automatic send(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            to_dev <= fr[i];
            repeat (bit_cnt - 1) @(posedge clk);
        end
    endtask

    // Sample frames mid-bit; a bad stop bit drops the byte
    always begin
        @(negedge from_dev);
        repeat (bit_cnt / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cnt) @(posedge clk);
            sh[i] = from_dev;
        end
        repeat (bit_cnt) @(posedge clk);
        if (from_dev === 1'b1) got.push_back(sh);
    end
endmodule
`default_nettype wire

// File: tb/mdu_uart_test.sv
`timescale 1ns/1ps
`default_nettype none
module mdu_uart_test;
    localparam int bc = 16;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [0:0] addr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic activate = 1'b1;
    logic [7:0] rdata;
    logic ser_in;
    logic ser_out;
    logic irq;
    int n_errors = 0;
    int compares = 0;
    int seed = 55749;
    logic [7:0] v;
    logic [7:0] q[$];

    always #2.5 clk = ~clk;

    mdu_uart #(.bit_cnt(bc)) DUT (.clk(clk), .sys_rst(sys_rst),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .activate(activate), .serial_music_in(ser_in),
        .serial_music_out(ser_out), .irq(irq));
    mdu_inst_model #(.bit_cnt(bc)) inst (.clk(clk), .to_dev(ser_in),
        .from_dev(ser_out));

    // ------------------------------------------------------------
    // Bus tasks and checks
    // ------------------------------------------------------------
    task automatic wr(input logic a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        compares++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            n_errors++;
        end
    endtask
    function automatic logic [7:0] stat_exp(input logic e, input logic b);
        return {e, b, 6'h00};
    endfunction
    task automatic chk_stat(input logic e);
        logic [7:0] s;
        rd(1'b1, s);
        chk("status", stat_exp(e, 1'b0), s);
    endtask
    // Command, then optional acknowledge read
    task automatic cmd(input logic [7:0] c, input logic ack);
        logic [7:0] s;
        wr(1'b1, c);
        chk_stat(!ack);
        chk("irq", {7'h00, ack}, {7'h00, irq});
        if (ack) begin
            rd(1'b0, s);
            chk("ack", mdu_pkg::ack_byte, s);
            chk_stat(1'b1);
        end
    endtask
    task automatic wrap_up;
        if (n_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        chk_stat(1'b1);
        wr(1'b0, 8'h55);
        inst.send(8'ha5);
        repeat (40) @(posedge clk);
        chk("tx count", 8'h00, 8'(inst.got.size()));
        chk_stat(1'b1);
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            if (v == mdu_pkg::cmd_reset || v == mdu_pkg::cmd_passthru) v = 8'h00;
            cmd(v, 1'b0);
        end
        cmd(mdu_pkg::cmd_reset, 1'b1);
        cmd(mdu_pkg::cmd_passthru, 1'b1);
        cmd(mdu_pkg::cmd_passthru, 1'b0);
        for (int i = 0; i < 3; i++) begin
            q.push_back(8'($random(seed)));
            inst.send(q[i]);
        end
        repeat (20) @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            chk("irq", 8'h01, {7'h00, irq});
            chk_stat(1'b0);
            rd(1'b0, v);
            chk("rx byte", q[i], v);
        end
        chk("irq", 8'h00, {7'h00, irq});
        q.delete();
        for (int i = 0; i < 3; i++) begin
            for (int k = 0; k < 100; k++) begin
                rd(1'b1, v);
                if (v[6] === 1'b0) break;
            end
            chk("busy", 8'h00, {7'h00, v[6]});
            q.push_back(8'($random(seed)));
            wr(1'b0, q[i]);
        end
        chk("irq", 8'h00, {7'h00, irq});
        for (int k = 0; k < 2000 && inst.got.size() < 3; k++) @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            chk("tx byte", q[i], inst.got[i]);
        end
        activate <= 1'b0;
        inst.send(8'h3c);
        repeat (20) @(posedge clk);
        chk("irq", 8'h00, {7'h00, irq});
        chk_stat(1'b0);
        activate <= 1'b1;
        repeat (3) @(posedge clk);
        chk("irq", 8'h01, {7'h00, irq});
        cmd(mdu_pkg::cmd_reset, 1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire
